/* File: rtl/isc_pkg.sv */
// shared constants and types for the i2c slave with clock stretching
package isc_pkg;

    // =========================================
    // mode field codes
    localparam logic [3:0] MODE_MASTER = 4'h8;
    localparam logic [3:0] MODE_FW_MASTER = 4'hb;
    localparam logic [3:0] MODE_SLV7 = 4'h6;
    localparam logic [3:0] MODE_SLV10 = 4'h7;
    localparam logic [3:0] MODE_SLV7_SP = 4'he;
    localparam logic [3:0] MODE_SLV10_SP = 4'hf;

    // =========================================
    // framing
    localparam logic [4:0] TEN_BIT_PATTERN = 5'h1e;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] BYTE_FIRST = 2'h0;
    localparam logic [1:0] BYTE_SECOND = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;

    // =========================================
    // slave sequencer
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK_OUT,
        ST_TX,
        ST_ACK_IN,
        ST_WAIT
    } isc_state_t;

    typedef struct packed {
        isc_state_t st;
        isc_state_t after;
        logic [3:0] cnt;
        logic [7:0] sr;
        logic [7:0] data_buf;
        logic [7:0] sa;
        logic [1:0] byte_no;
        logic bf;
        logic ov;
        logic intr;
        logic ua;
        logic ua_hold;
        logic rw;
        logic clock_release_bit;
        logic ten_full;
        logic ack_drive;
        logic data_ack;
        logic rd7;
        logic scl_oe;
        logic sda_oe;
    } isc_core_t;

    localparam isc_core_t CORE_RESET = '{st: ST_IDLE, after: ST_IDLE, clock_release_bit: 1'b1, default: '0};

endpackage

/* File: rtl/isc_bus_if.sv */
// sampled bus levels and events passed from the pin sampler to the core
`timescale 1ns/1ps
interface isc_bus_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;

    modport drv (output scl, output sda, output scl_rise, output scl_fall, output start, output stop);
    modport mon (input scl, input sda, input scl_rise, input scl_fall, input start, input stop);
endinterface

/* File: rtl/isc_sampler.sv */
// two-flop synchroniser and edge / start / stop detection for scl and sda
`timescale 1ns/1ps
module isc_sampler (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    isc_bus_if.drv bus
);

    typedef struct packed {
        logic s1_scl;
        logic s1_sda;
        logic s2_scl;
        logic s2_sda;
        logic s3_scl;
        logic s3_sda;
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } isc_samp_t;

    isc_samp_t samp_ff;
    isc_samp_t nxt_samp;

    // =========================================
    // edge logic looks only at stages two and three
    always_comb begin
        nxt_samp = samp_ff;
        nxt_samp.s1_scl = scl_in;
        nxt_samp.s1_sda = sda_in;
        nxt_samp.s2_scl = samp_ff.s1_scl;
        nxt_samp.s2_sda = samp_ff.s1_sda;
        nxt_samp.s3_scl = samp_ff.s2_scl;
        nxt_samp.s3_sda = samp_ff.s2_sda;
        nxt_samp.rise = samp_ff.s2_scl && !samp_ff.s3_scl;
        nxt_samp.fall = !samp_ff.s2_scl && samp_ff.s3_scl;
        nxt_samp.start = samp_ff.s2_scl && samp_ff.s3_scl && !samp_ff.s2_sda && samp_ff.s3_sda;
        nxt_samp.stop = samp_ff.s2_scl && samp_ff.s3_scl && samp_ff.s2_sda && !samp_ff.s3_sda;
    end

    // idle bus is high, so reset to one to avoid a false edge
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            samp_ff <= '{s1_scl: 1'b1, s1_sda: 1'b1, s2_scl: 1'b1, s2_sda: 1'b1,
                         s3_scl: 1'b1, s3_sda: 1'b1, default: '0};
        end else begin
            samp_ff <= nxt_samp;
        end
    end

    assign bus.scl = samp_ff.s3_scl;
    assign bus.sda = samp_ff.s3_sda;
    assign bus.scl_rise = samp_ff.rise;
    assign bus.scl_fall = samp_ff.fall;
    assign bus.start = samp_ff.start;
    assign bus.stop = samp_ff.stop;

endmodule // isc_sampler

/* File: rtl/isc_slave.sv */
// i2c slave core: addressing, acknowledge, receive, transmit and clock stretching
`timescale 1ns/1ps
// Notes on behaviour
// R1: port stays inert until the port enable bit is set.
// R2: four-bit mode field selects master, 7/10-bit slave, start/stop variants, firmware master; here both master codes leave the slave core inert.
// R3: address match always interrupts; start and stop interrupt when the mode enables it.
// R4: on match or later data byte, device acknowledges and copies shift register to buffer.
// R5: full or overflow already set: no acknowledge, buffer kept, interrupt still set.
// R6: buffer read clears buffer full; overflow clears only by software.
// R7: after start, shift eight bits in on rising serial clock edges.
// R8: compare shift bits 7:1 with slave address on eighth falling edge.
// R9: on match load buffer, set full, acknowledge, interrupt on ninth falling edge.
// R10: 10-bit first byte is 11110, two top address bits, write; slave checks seven bits.
// R11: 10-bit address bytes set flags and hold clock until address register written.
// R12: write address match clears read/write status, loads buffer, drives acknowledge low.
// R13: interrupt flag set once per data byte, held until software clears it.
// R14: with stretch enabled, hold clock after each received data byte until released.
// R15: read address match sets read/write, acknowledges, holds clock regardless of stretch enable.
// R16: transmit write also loads shift register; bits change on falling clock edges.
// R17: latch master acknowledge on ninth rising edge; not-acknowledge resets and waits.
// R18: 7-bit receive, stretch enabled, buffer full at ninth fall clears clock release.
// R19: software may set the clock release bit at any time.
// R20: 10-bit address bytes stretch on update flag without clearing clock release.
// R21: transmit, buffer empty after ninth fall clears clock release, stretch enable ignored.
// R22: 10-bit third address byte with read: no update flag, transmit, stretch on empty buffer.
// R23: release bit low forces clock low; clock low only once already sampled low.
module isc_slave (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic port_enable_bit_in,
    input wire logic [3:0] mode_in,
    input wire logic stretch_enable_bit_in,
    input wire logic address_wr_in,
    input wire logic [7:0] address_in,
    input wire logic tx_wr_in,
    input wire logic [7:0] tx_data_in,
    input wire logic buffer_rd_in,
    input wire logic clock_release_set_in,
    input wire logic clock_release_clr_in,
    input wire logic overflow_clr_in,
    input wire logic interrupt_clr_in,
    output logic scl_out,
    output logic scl_oe_out,
    output logic sda_out,
    output logic sda_oe_out,
    output logic [7:0] buffer_out,
    output logic buffer_full_out,
    output logic overflow_out,
    output logic interrupt_out,
    output logic update_address_out,
    output logic read_write_out,
    output logic clock_release_out
);

    isc_pkg::isc_core_t core_ff;
    isc_pkg::isc_core_t nxt_core;
    logic slave;
    logic ten_mode;
    logic sp_mode;
    logic ev_ok;
    logic addr_hit;
    logic addr_rd;
    logic tx_load_ok;

    isc_bus_if bus ();

    isc_sampler u_sampler (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .bus(bus)
    );

    // =========================================
    // mode decode
    // R1 enable gate
    // R2 mode selection
    assign ten_mode = (mode_in == isc_pkg::MODE_SLV10) || (mode_in == isc_pkg::MODE_SLV10_SP);
    assign sp_mode = (mode_in == isc_pkg::MODE_SLV7_SP) || (mode_in == isc_pkg::MODE_SLV10_SP);
    assign slave = port_enable_bit_in && (ten_mode || sp_mode || mode_in == isc_pkg::MODE_SLV7);
    assign ev_ok = slave && !bus.start && !bus.stop;
    // never mid-byte, so a late load cannot corrupt a shift in progress
    assign tx_load_ok = !(core_ff.st == isc_pkg::ST_RX || (core_ff.st == isc_pkg::ST_TX && core_ff.cnt != 4'h0));

    // =========================================
    // address match
    always_comb begin
        addr_hit = 1'b0;
        addr_rd = core_ff.sr[0];
        if (core_ff.byte_no == isc_pkg::BYTE_DATA) begin
            addr_hit = 1'b1;
            addr_rd = 1'b0;
        end else if (!ten_mode) begin
            // R8 seven-bit compare
            addr_hit = core_ff.sr[7:1] == core_ff.sa[7:1];
        end else if (core_ff.byte_no == isc_pkg::BYTE_FIRST) begin
            // R10 ten-bit header
            // R22 read header only after full match
            addr_hit = (core_ff.sr[7:3] == isc_pkg::TEN_BIT_PATTERN) && (core_ff.sr[2:1] == core_ff.sa[2:1])
                       && (!core_ff.sr[0] || core_ff.ten_full);
        end else begin
            addr_hit = core_ff.sr == core_ff.sa;
            addr_rd = 1'b0;
        end
    end

    // =========================================
    // sequencer
    always_comb begin
        nxt_core = core_ff;
        // software clears first so that hardware sets below win
        // R6 read clears full
        if (buffer_rd_in) begin
            nxt_core.bf = 1'b0;
        end
        if (overflow_clr_in) begin
            nxt_core.ov = 1'b0;
        end
        if (interrupt_clr_in) begin
            nxt_core.intr = 1'b0;
        end
        if (clock_release_clr_in) begin
            nxt_core.clock_release_bit = 1'b0;
        end
        // R11 address write releases
        if (address_wr_in) begin
            nxt_core.sa = address_in;
            nxt_core.ua = 1'b0;
            nxt_core.ua_hold = 1'b0;
        end
        // R16 transmit load
        if (tx_wr_in) begin
            nxt_core.data_buf = tx_data_in;
            nxt_core.bf = 1'b1;
            if (tx_load_ok) begin
                nxt_core.sr = tx_data_in;
            end
        end
        if (!slave) begin
            nxt_core.st = isc_pkg::ST_IDLE;
        end else if (bus.stop) begin
            nxt_core.st = isc_pkg::ST_IDLE;
            nxt_core.ten_full = 1'b0;
            // R3 stop interrupt
            if (sp_mode) begin
                nxt_core.intr = 1'b1;
            end
        end else if (bus.start) begin
            // R7 wait for start
            nxt_core.st = isc_pkg::ST_RX;
            nxt_core.cnt = 4'h0;
            nxt_core.byte_no = isc_pkg::BYTE_FIRST;
            if (sp_mode) begin
                nxt_core.intr = 1'b1;
            end
        end else begin
            case (core_ff.st)
                isc_pkg::ST_RX: begin
                    if (bus.scl_rise && core_ff.cnt < isc_pkg::BITS_PER_BYTE) begin
                        // R7 sample on rise
                        nxt_core.sr = {core_ff.sr[6:0], bus.sda};
                        nxt_core.cnt = core_ff.cnt + 4'h1;
                    end else if (bus.scl_fall && core_ff.cnt == isc_pkg::BITS_PER_BYTE) begin
                        if (!addr_hit) begin
                            nxt_core.st = isc_pkg::ST_WAIT;
                            nxt_core.ten_full = 1'b0;
                        end else begin
                            nxt_core.st = isc_pkg::ST_ACK_OUT;
                            nxt_core.cnt = 4'h0;
                            // R5 overflow withholds acknowledge
                            nxt_core.ack_drive = !(core_ff.bf || core_ff.ov);
                            nxt_core.data_ack = core_ff.byte_no == isc_pkg::BYTE_DATA;
                            nxt_core.after = addr_rd ? isc_pkg::ST_TX : isc_pkg::ST_RX;
                            nxt_core.rd7 = addr_rd && !ten_mode;
                            if (core_ff.bf || core_ff.ov) begin
                                nxt_core.ov = 1'b1;
                            end else begin
                                // R4 copy to buffer
                                // R9 load and set full
                                nxt_core.data_buf = core_ff.sr;
                                nxt_core.bf = nxt_core.bf || !addr_rd;
                            end
                            // R12 write direction
                            // R15 read direction
                            if (core_ff.byte_no != isc_pkg::BYTE_DATA) begin
                                nxt_core.rw = addr_rd;
                            end
                            // R11 update flag per address byte
                            if (ten_mode && core_ff.byte_no != isc_pkg::BYTE_DATA && !addr_rd) begin
                                nxt_core.ua = 1'b1;
                            end
                            if (addr_rd || !ten_mode || core_ff.byte_no != isc_pkg::BYTE_FIRST) begin
                                nxt_core.byte_no = isc_pkg::BYTE_DATA;
                            end else begin
                                nxt_core.byte_no = isc_pkg::BYTE_SECOND;
                            end
                            if (ten_mode && core_ff.byte_no == isc_pkg::BYTE_SECOND) begin
                                nxt_core.ten_full = 1'b1;
                            end
                        end
                    end
                end
                isc_pkg::ST_ACK_OUT: begin
                    if (bus.scl_fall) begin
                        nxt_core.st = core_ff.after;
                        nxt_core.cnt = 4'h0;
                        // R13 one flag per byte
                        nxt_core.intr = 1'b1;
                        if (nxt_core.ua) begin
                            // R20 hold on update flag
                            nxt_core.ua_hold = 1'b1;
                        end else if (core_ff.after == isc_pkg::ST_TX) begin
                            // R15 seven-bit read always stretches
                            // R21 empty buffer stretches
                            if (core_ff.rd7 || !nxt_core.bf) begin
                                nxt_core.clock_release_bit = 1'b0;
                            end
                        end else if (core_ff.data_ack && stretch_enable_bit_in && nxt_core.bf) begin
                            // R14 receive stretch
                            // R18 full at ninth fall
                            nxt_core.clock_release_bit = 1'b0;
                        end
                    end
                end
                isc_pkg::ST_TX: begin
                    // R16 shift out on fall
                    if (bus.scl_fall) begin
                        nxt_core.sr = {core_ff.sr[6:0], 1'b0};
                        nxt_core.cnt = core_ff.cnt + 4'h1;
                        if (core_ff.cnt == isc_pkg::BITS_PER_BYTE - 4'h1) begin
                            nxt_core.st = isc_pkg::ST_ACK_IN;
                            nxt_core.cnt = 4'h0;
                            nxt_core.bf = 1'b0;
                        end
                    end
                end
                isc_pkg::ST_ACK_IN: begin
                    if (bus.scl_rise && bus.sda) begin
                        // R17 not-acknowledge resets
                        nxt_core.st = isc_pkg::ST_WAIT;
                        nxt_core.rw = 1'b0;
                        nxt_core.bf = 1'b0;
                        nxt_core.ua = 1'b0;
                    end else if (bus.scl_fall) begin
                        nxt_core.st = isc_pkg::ST_TX;
                        nxt_core.cnt = 4'h0;
                        nxt_core.intr = 1'b1;
                        // R21 empty buffer stretches
                        if (!nxt_core.bf) begin
                            nxt_core.clock_release_bit = 1'b0;
                        end
                    end
                end
                isc_pkg::ST_IDLE, isc_pkg::ST_WAIT: begin
                    nxt_core.cnt = 4'h0;
                end
                default: begin
                    nxt_core.st = isc_pkg::ST_IDLE;
                end
            endcase
        end
        // R19 software set wins
        if (clock_release_set_in) begin
            nxt_core.clock_release_bit = 1'b1;
        end
        nxt_core.sda_oe = slave && ((nxt_core.st == isc_pkg::ST_ACK_OUT && nxt_core.ack_drive)
                                    || (nxt_core.st == isc_pkg::ST_TX && !nxt_core.sr[7]));
        // R23 pull low only once the line is already low
        nxt_core.scl_oe = slave && (!nxt_core.clock_release_bit || nxt_core.ua_hold) && (core_ff.scl_oe || !bus.scl);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            core_ff <= isc_pkg::CORE_RESET;
        end else begin
            core_ff <= nxt_core;
        end
    end

    // open-drain pins only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_out = core_ff.scl_oe;
    assign sda_oe_out = core_ff.sda_oe;
    assign buffer_out = core_ff.data_buf;
    assign buffer_full_out = core_ff.bf;
    assign overflow_out = core_ff.ov;
    assign interrupt_out = core_ff.intr;
    assign update_address_out = core_ff.ua;
    assign read_write_out = core_ff.rw;
    assign clock_release_out = core_ff.clock_release_bit;

    // =========================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_disabled_quiet;
        !port_enable_bit_in |=> !core_ff.scl_oe && !core_ff.sda_oe;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("pins driven while disabled"); // R1

    property p_no_ack_when_full;
        ev_ok && core_ff.st == isc_pkg::ST_RX && bus.scl_fall && core_ff.cnt == isc_pkg::BITS_PER_BYTE
        && core_ff.bf |=> !core_ff.sda_oe && (core_ff.ov || core_ff.st == isc_pkg::ST_WAIT);
    endproperty
    a_no_ack_when_full: assert property (p_no_ack_when_full) else $error("ack given with buffer full"); // R5

    property p_ov_sticky;
        core_ff.ov && !overflow_clr_in |=> core_ff.ov;
    endproperty
    a_ov_sticky: assert property (p_ov_sticky) else $error("overflow cleared without software"); // R6

    property p_rd_clears_full;
        buffer_rd_in && !tx_wr_in && core_ff.st != isc_pkg::ST_RX |=> !core_ff.bf;
    endproperty
    a_rd_clears_full: assert property (p_rd_clears_full) else $error("read left buffer full"); // R6

    property p_shift_count;
        ev_ok && core_ff.st == isc_pkg::ST_RX && bus.scl_rise && core_ff.cnt < isc_pkg::BITS_PER_BYTE
        |=> core_ff.cnt == $past(core_ff.cnt) + 4'h1 && core_ff.sr[0] == $past(bus.sda);
    endproperty
    a_shift_count: assert property (p_shift_count) else $error("receive bit not shifted"); // R7

    property p_int_ninth;
        ev_ok && core_ff.st == isc_pkg::ST_ACK_OUT && bus.scl_fall |=> core_ff.intr;
    endproperty
    a_int_ninth: assert property (p_int_ninth) else $error("no interrupt at ninth fall"); // R9

    property p_read_stretch;
        ev_ok && core_ff.st == isc_pkg::ST_ACK_OUT && bus.scl_fall && core_ff.rd7 && !clock_release_set_in
        |=> !core_ff.clock_release_bit && core_ff.scl_oe;
    endproperty
    a_read_stretch: assert property (p_read_stretch) else $error("read address did not stretch"); // R15

    property p_nack_reset;
        ev_ok && core_ff.st == isc_pkg::ST_ACK_IN && bus.scl_rise && bus.sda
        |=> core_ff.st == isc_pkg::ST_WAIT && !core_ff.rw && !core_ff.sda_oe;
    endproperty
    a_nack_reset: assert property (p_nack_reset) else $error("not-acknowledge did not reset"); // R17

    property p_release_set;
        clock_release_set_in |=> core_ff.clock_release_bit;
    endproperty
    a_release_set: assert property (p_release_set) else $error("clock release set refused"); // R19

    property p_addr_wr_release;
        address_wr_in && core_ff.st != isc_pkg::ST_RX |=> !core_ff.ua && !core_ff.ua_hold;
    endproperty
    a_addr_wr_release: assert property (p_addr_wr_release) else $error("address write kept hold"); // R11

    property p_scl_hold;
        slave && !core_ff.clock_release_bit && !bus.scl && !clock_release_set_in |=> core_ff.scl_oe;
    endproperty
    a_scl_hold: assert property (p_scl_hold) else $error("clock not held while release low"); // R23

    c_ack_given: cover property (core_ff.st == isc_pkg::ST_ACK_OUT && core_ff.sda_oe);
    c_tx_byte: cover property (core_ff.st == isc_pkg::ST_ACK_IN && bus.scl_rise && !bus.sda);
    c_ua_hold: cover property (core_ff.ua_hold && core_ff.scl_oe);
    c_rx_stretch: cover property (core_ff.data_ack && !core_ff.clock_release_bit && core_ff.scl_oe);

endmodule // isc_slave

/* File: bench/isc_master.sv */
// bus master model on the far side of the slave, open-drain with pull-ups
`timescale 1ns/1ps
module isc_master (
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_low_out,
    output logic sda_low_out,
    output logic hung_out
);
    // =========================================
    // bit timing, 160 ns per bit
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
        hung_out = 1'b0;
    end
    // bounded wait for a stretched clock, so a stuck slave ends the run
    task automatic rise();
        int n;
        n = 0;
        scl_low_out = 1'b0;
        while (!scl_in && n < 5000) begin
            #10;
            n++;
        end
        if (!scl_in) hung_out = 1'b1;
        #80;
    endtask
    task automatic bit_x(input logic v, output logic s);
        sda_low_out = !v;
        #80;
        rise();
        s = sda_in;
        scl_low_out = 1'b1;
    endtask
    // =========================================
    // framing; scl stands high between frames
    task automatic start_c();
        sda_low_out = 1'b0;
        #80;
        rise();
        sda_low_out = 1'b1;
        #80;
        scl_low_out = 1'b1;
    endtask
    task automatic stop_c();
        sda_low_out = 1'b1;
        #80;
        rise();
        sda_low_out = 1'b0;
        #80;
    endtask
    // one byte msb first, then the ninth bit; mack drives it low when reading
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
            q = {q[6:0], s};
        end
        bit_x(!mack, s);
        ack = !s;
    endtask
endmodule // isc_master

/* File: bench/isc_slave_test.sv */
// self-checking bench for the i2c slave with clock stretching
`timescale 1ns/1ps
module isc_slave_test;
    logic clk_in;
    logic rst_in;
    logic en;
    logic stretch_enable_bit;
    logic [3:0] mode;
    logic [7:0] addr;
    logic [7:0] txd;
    logic [6:0] stb;
    logic scl_oe, sda_oe, m_scl, m_sda, hung, bf, ov, intr, ua, rw, clock_release_bit, ack;
    logic [7:0] buf_q;
    logic [7:0] q;
    int bad_count;
    int n_compared;
    // pull-ups: a released line reads high
    wire scl_w = !(scl_oe | m_scl);
    wire sda_w = !(sda_oe | m_sda);
    isc_slave dut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_w), .sda_in(sda_w), .port_enable_bit_in(en),
        .mode_in(mode), .stretch_enable_bit_in(stretch_enable_bit), .address_wr_in(stb[0]), .address_in(addr),
        .tx_wr_in(stb[1]), .tx_data_in(txd), .buffer_rd_in(stb[2]), .clock_release_set_in(stb[3]),
        .clock_release_clr_in(stb[4]), .overflow_clr_in(stb[5]), .interrupt_clr_in(stb[6]), .scl_out(),
        .scl_oe_out(scl_oe), .sda_out(), .sda_oe_out(sda_oe), .buffer_out(buf_q), .buffer_full_out(bf),
        .overflow_out(ov), .interrupt_out(intr), .update_address_out(ua), .read_write_out(rw),
        .clock_release_out(clock_release_bit));
    isc_master m (.scl_in(scl_w), .sda_in(sda_w), .scl_low_out(m_scl), .sda_low_out(m_sda), .hung_out(hung));
    // =========================================
    // tasks
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // strobes: 0 addr, 1 tx, 2 read, 3 release set, 4 release clr, 5 ovf clr, 6 int clr
    task automatic pulse(input int i, input logic [7:0] d = 8'h00);
        @(posedge clk_in);
        stb[i] <= 1'b1;
        addr <= (i == 0) ? d : addr;
        txd <= d;
        @(posedge clk_in);
        stb[i] <= 1'b0;
        #1;
    endtask
    // bits: full, overflow, interrupt, update, read, release
    task automatic flags(input logic [7:0] e);
        repeat (10) @(posedge clk_in);
        #1;
        cmp({2'h0, bf, ov, intr, ua, rw, clock_release_bit}, e);
    endtask
    task automatic wb(input logic [7:0] b, input logic a);
        m.xfer(b, 1'b0, q, ack);
        cmp({7'h0, ack}, {7'h0, a});
    endtask
    task automatic rb(input logic [7:0] e, input logic mack);
        m.xfer(8'hff, mack, q, ack);
        cmp(q, e);
    endtask
    task automatic end_sim();
        if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge hung) begin
        bad_count++;
        end_sim();
    end
    // =========================================
    // scenarios
    initial begin
        {rst_in, en, stretch_enable_bit, mode, addr, txd, stb} = {3'h4, isc_pkg::MODE_SLV7, 23'h0};
        bad_count = 0;
        n_compared = 0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        flags(8'h01);
        pulse(0, 8'ha0);
        m.start_c();
        wb(8'ha0, 1'b0);
        flags(8'h01);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_in);
            en <= 1'b1;
            mode <= i ? isc_pkg::MODE_FW_MASTER : isc_pkg::MODE_MASTER;
            m.start_c();
            wb(8'ha0, 1'b0);
        end
        @(posedge clk_in);
        mode <= isc_pkg::MODE_SLV7;
        m.start_c();
        wb(8'ha2, 1'b0);
        flags(8'h01);
        m.start_c();
        wb(8'ha0, 1'b1);
        flags(8'h29);
        cmp(buf_q, 8'ha0);
        pulse(2);
        pulse(6);
        wb(8'h3c, 1'b1);
        flags(8'h29);
        wb(8'h55, 1'b0);
        cmp(buf_q, 8'h3c);
        pulse(2);
        flags(8'h19);
        pulse(5);
        pulse(6);
        flags(8'h01);
        m.stop_c();
        @(posedge clk_in);
        mode <= isc_pkg::MODE_SLV7_SP;
        stretch_enable_bit <= 1'b1;
        m.start_c();
        flags(8'h09);
        pulse(6);
        wb(8'ha0, 1'b1);
        pulse(2);
        pulse(6);
        wb(8'h81, 1'b1);
        flags(8'h28);
        cmp({7'h0, scl_oe}, 8'h01);
        pulse(3);
        flags(8'h29);
        cmp({7'h0, scl_oe}, 8'h00);
        pulse(2);
        pulse(6);
        m.stop_c();
        flags(8'h09);
        @(posedge clk_in);
        mode <= isc_pkg::MODE_SLV7;
        stretch_enable_bit <= 1'b0;
        pulse(6);
        m.start_c();
        wb(8'ha1, 1'b1);
        flags(8'h0a);
        pulse(6);
        pulse(1, 8'hc3);
        pulse(3);
        rb(8'hc3, 1'b1);
        flags(8'h0a);
        pulse(6);
        pulse(1, 8'h5a);
        pulse(3);
        rb(8'h5a, 1'b0);
        flags(8'h01);
        m.stop_c();
        @(posedge clk_in);
        mode <= isc_pkg::MODE_SLV10;
        pulse(0, 8'hf4);
        m.start_c();
        wb(8'hf4, 1'b1);
        flags(8'h2d);
        cmp({7'h0, scl_oe}, 8'h01);
        pulse(0, 8'ha5);
        pulse(2);
        pulse(6);
        wb(8'ha5, 1'b1);
        flags(8'h2d);
        pulse(0, 8'hf4);
        pulse(2);
        pulse(6);
        wb(8'h11, 1'b1);
        cmp(buf_q, 8'h11);
        pulse(2);
        pulse(6);
        @(posedge clk_in);
        mode <= isc_pkg::MODE_SLV10_SP;
        m.start_c();
        flags(8'h09);
        wb(8'hf5, 1'b1);
        flags(8'h0a);
        pulse(1, 8'h96);
        pulse(3);
        rb(8'h96, 1'b0);
        m.stop_c();
        end_sim();
    end
endmodule // isc_slave_test
